// file: core/flags_image.sv
// flags image pushed for a delivered event and the live flags left behind
// assumes purely combinational use; the caller registers live_after only, pushed_image feeds the push word directly
`timescale 1ns/1ns
`default_nettype none

module flags_image (
	input  wire logic [31:0] guest_flags,
	input  wire logic        ivt_path,
	input  wire logic        trap_gate,
	output logic      [31:0] pushed_image,
	output logic      [31:0] live_after
);

	logic low_io_privilege_level;

	assign low_io_privilege_level = guest_flags[vm_inject_pkg::FL_IO_PRIVILEGE_LEVEL_LSB +: 2] != vm_inject_pkg::IO_PRIVILEGE_LEVEL_TOP;

	always_comb begin
		// resume flag passes through untouched whatever the event type
		pushed_image = guest_flags;
		if (ivt_path && low_io_privilege_level) begin
			pushed_image[vm_inject_pkg::FL_IO_PRIVILEGE_LEVEL_LSB +: 2] = vm_inject_pkg::IO_PRIVILEGE_LEVEL_TOP;
			pushed_image[vm_inject_pkg::FL_IF] = guest_flags[vm_inject_pkg::FL_VIF];
		end
	end

	always_comb begin
		// same update as an ordinary delivery: vector-table rules on the ivt path, descriptor-table rules otherwise
		live_after = guest_flags;
		live_after[vm_inject_pkg::FL_TF] = 1'b0;
		if (ivt_path) begin
			if (low_io_privilege_level) begin
				live_after[vm_inject_pkg::FL_VIF] = 1'b0;
			end else begin
				live_after[vm_inject_pkg::FL_IF] = 1'b0;
			end
		end else begin
			live_after[vm_inject_pkg::FL_NT] = 1'b0;
			live_after[vm_inject_pkg::FL_RF] = 1'b0;
			live_after[vm_inject_pkg::FL_VM] = 1'b0;
			if (!trap_gate) begin
				live_after[vm_inject_pkg::FL_IF] = 1'b0;
			end
		end
	end

endmodule
`default_nettype wire

// file: core/vm_entry_event_injection.sv
// delivers the event injected at the end of a virtual-machine entry
// assumes an apb master on core_clk, a descriptor fetch unit that answers
// fetch_req with fetch_ack/fetch_resp, and a stack writer taking push words
//
// Overview of operation
// - pushed flags are guest flags, resume untouched
// - live flags then updated as normal delivery
// - hardware-type events push guest pointer unmodified
// - software-type events push pointer plus length
// - nested exception pushes or saves unmodified pointer
// - pushed pointer width chosen as normal delivery
// - error-code control bit 11 pushes error field
// - injection never alters debug registers or msr
// - no io-privilege fault for virtual-8086 software interrupt
// - clear redirect bit: vector table, adjusted image
// - set redirect bit: protected handler regardless
// - redirection check only for software interrupts
// - software interrupts and software exceptions need descriptor privilege at least current
// - other events skip descriptor privilege check
// - branch enable set logs a branch record
// - last-exception records follow branch enable too
// - first nested after hardware-type event sets external bit
// - first nested after software interrupt or software exception clears external bit
// - later nested sets external bit; double fault zero
// - injected event itself never exits
// - task gate and nested exceptions exit normally
// - exit records injected event in vectoring field; exits on later levels record the nested event being delivered
// - nested exception exits when bitmap bit set
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module vm_entry_event_injection (
	input  wire logic                        core_clk,
	input  wire logic                        reset,
	input  wire logic                        ce,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [7:0]                  paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	output vm_inject_pkg::fetch_req_t        fetch_req,
	input  wire logic                        fetch_ack,
	input  wire vm_inject_pkg::fetch_resp_t  fetch_resp,
	input  wire logic                        task_switch_exits,
	output logic                             push_valid,
	input  wire logic                        push_ready,
	output vm_inject_pkg::push_t             push,
	output logic                             vm_exit,
	output logic                             branch_record_log,
	output logic                             ler_update,
	output logic                             busy,
	output logic      [31:0]                 live_flags,
	output logic      [31:0]                 vectoring_info
);

	// ****************************************************************
	// address decode
	// ****************************************************************
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a[1:0] == 2'h0) && (a <= vm_inject_pkg::OFS_LIVE_FLAGS);
	endfunction

	logic [31:0]                intr_info;
	logic [31:0]                err_code;
	logic [31:0]                instr_len;
	logic [31:0]                guest_flags;
	logic [63:0]                guest_ip;
	logic [31:0]                exc_bitmap;
	logic [4:0]                 mode;
	logic [31:0]                debug_control_msr;
	vm_inject_pkg::state_t      state;
	vm_inject_pkg::state_t      next_state;
	vm_inject_pkg::fetch_resp_t resp_q;
	logic [1:0]                 depth;
	logic [7:0]                 cur_vector;
	logic                       cur_has_code;
	logic [31:0]                cur_code;
	logic                       ivt_path;
	logic                       done;
	logic                       exited;
	logic                       shutdown;
	logic                       setup;
	logic                       wr_access;
	logic                       start;
	logic [2:0]                 inj_type;
	logic                       sw_like;
	logic                       ext_value;
	logic                       redir_candidate;
	logic                       dpl_fault;
	logic                       any_fault;
	logic [7:0]                 nest_vector;
	logic [31:0]                nest_code;
	logic                       nest_has_code;
	logic                       nest_exits;
	logic                       gate_exits;
	logic [31:0]                img_flags;
	logic [31:0]                img_live;
	logic [63:0]                ret_ip;
	logic [63:0]                width_mask;
	logic [31:0]                cur_vectoring;

	assign setup     = psel && !penable;
	assign wr_access = psel && penable && pwrite && mapped(paddr);
	assign pready    = 1'b1;
	assign pslverr   = psel && penable && !mapped(paddr);
	assign busy      = state != vm_inject_pkg::ST_IDLE;
	assign start     = ce && wr_access && (paddr == vm_inject_pkg::OFS_CONTROL)
	                   && pwdata[vm_inject_pkg::CTRL_START_BIT] && !busy;

	// ****************************************************************
	// software-written fields
	// ****************************************************************
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			intr_info         <= vm_inject_pkg::REG_RESET;
			err_code          <= vm_inject_pkg::REG_RESET;
			instr_len         <= vm_inject_pkg::REG_RESET;
			guest_flags       <= vm_inject_pkg::REG_RESET;
			guest_ip          <= vm_inject_pkg::IP_RESET;
			exc_bitmap        <= vm_inject_pkg::REG_RESET;
			mode              <= 5'h00;
			debug_control_msr <= vm_inject_pkg::REG_RESET;
		end else if (ce && wr_access && !busy) begin
			// fields are frozen while an injection runs so the pushed values stay coherent
			case (paddr)
				vm_inject_pkg::OFS_INTR_INFO:   intr_info <= pwdata;
				vm_inject_pkg::OFS_ERR_CODE:    err_code <= pwdata;
				vm_inject_pkg::OFS_INSTR_LEN:   instr_len <= pwdata;
				vm_inject_pkg::OFS_GUEST_FLAGS: guest_flags <= pwdata;
				vm_inject_pkg::OFS_GUEST_IP_LO: guest_ip[31:0] <= pwdata;
				vm_inject_pkg::OFS_GUEST_IP_HI: guest_ip[63:32] <= pwdata;
				vm_inject_pkg::OFS_EXC_BITMAP:  exc_bitmap <= pwdata;
				vm_inject_pkg::OFS_MODE:        mode <= pwdata[4:0];
				// only software writes reach the debug msr, never delivery
				vm_inject_pkg::OFS_DEBUG_CTL:   debug_control_msr <= pwdata;
				default: ;
			endcase
		end
	end

	// ****************************************************************
	// register reads, captured in the setup cycle
	// ****************************************************************
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			prdata <= vm_inject_pkg::REG_RESET;
		end else if (ce && setup) begin
			case (paddr)
				vm_inject_pkg::OFS_INTR_INFO:   prdata <= intr_info;
				vm_inject_pkg::OFS_ERR_CODE:    prdata <= err_code;
				vm_inject_pkg::OFS_INSTR_LEN:   prdata <= instr_len;
				vm_inject_pkg::OFS_GUEST_FLAGS: prdata <= guest_flags;
				vm_inject_pkg::OFS_GUEST_IP_LO: prdata <= guest_ip[31:0];
				vm_inject_pkg::OFS_GUEST_IP_HI: prdata <= guest_ip[63:32];
				vm_inject_pkg::OFS_EXC_BITMAP:  prdata <= exc_bitmap;
				vm_inject_pkg::OFS_MODE:        prdata <= {27'h0000000, mode};
				vm_inject_pkg::OFS_DEBUG_CTL:   prdata <= debug_control_msr;
				vm_inject_pkg::OFS_STATUS:      prdata <= {22'h000000, depth, state,
				                                           shutdown, exited, done, busy, ivt_path};
				vm_inject_pkg::OFS_VECTORING:   prdata <= vectoring_info;
				vm_inject_pkg::OFS_LIVE_FLAGS:  prdata <= live_flags;
				default:                        prdata <= vm_inject_pkg::REG_RESET;
			endcase
		end
	end

	// ****************************************************************
	// event classification
	// ****************************************************************
	assign inj_type = intr_info[vm_inject_pkg::INFO_TYPE_LSB +: 3];
	assign sw_like  = (inj_type == vm_inject_pkg::TYPE_SW_INT)
	                  || (inj_type == vm_inject_pkg::TYPE_PSW_EXC)
	                  || (inj_type == vm_inject_pkg::TYPE_SW_EXC);
	// only software interrupts in virtual-8086 mode with extensions are redirected
	assign redir_candidate = (inj_type == vm_inject_pkg::TYPE_SW_INT)
	                         && guest_flags[vm_inject_pkg::FL_VM]
	                         && mode[vm_inject_pkg::MODE_VME_BIT];

	// privilege check only for non-redirected software interrupts and software
	// exceptions, and never against io privilege
	always_comb begin
		dpl_fault = 1'b0;
		if ((depth == 2'h0) && ((inj_type == vm_inject_pkg::TYPE_SW_INT)
		    || (inj_type == vm_inject_pkg::TYPE_SW_EXC))) begin
			dpl_fault = resp_q.gate_dpl < mode[vm_inject_pkg::MODE_CPL_LSB +: 2];
		end
	end

	// first nested fault: software interrupts and software exceptions clear, all other types set
	assign ext_value = (depth == 2'h0)
	                   ? !((inj_type == vm_inject_pkg::TYPE_SW_INT)
	                       || (inj_type == vm_inject_pkg::TYPE_SW_EXC))
	                   : 1'b1;
	assign any_fault = resp_q.fault || dpl_fault;

	always_comb begin
		nest_vector   = vm_inject_pkg::VEC_GP;
		nest_has_code = 1'b1;
		nest_code     = {20'h00000, cur_vector, vm_inject_pkg::IDT_CODE_TAIL, ext_value};
		if (resp_q.fault) begin
			nest_vector   = resp_q.fault_vector;
			nest_has_code = resp_q.fault_has_code;
			nest_code     = {resp_q.fault_code[31:1], ext_value};
		end
		if (depth == vm_inject_pkg::DEPTH_DF) begin
			nest_vector   = vm_inject_pkg::VEC_DF;
			nest_has_code = 1'b1;
			nest_code     = vm_inject_pkg::DF_CODE;
		end
	end

	// bitmap bit picks guest delivery or an exit
	assign nest_exits = exc_bitmap[nest_vector[4:0]];
	assign gate_exits = resp_q.task_gate && task_switch_exits;

	// injected event on the first level, otherwise the nested one being delivered
	assign cur_vectoring = (depth == 2'h0)
	                       ? {1'b1, 19'h00000, intr_info[vm_inject_pkg::INFO_ERR_BIT],
	                          inj_type, cur_vector}
	                       : {1'b1, 19'h00000, cur_has_code, vm_inject_pkg::TYPE_HW_EXC, cur_vector};

	// ****************************************************************
	// pushed values
	// ****************************************************************
	flags_image u_flags (
		.guest_flags  (guest_flags),
		.ivt_path     (ivt_path),
		.trap_gate    (resp_q.trap_gate),
		.pushed_image (img_flags),
		.live_after   (img_live)
	);

	always_comb begin
		case (mode[vm_inject_pkg::MODE_WIDTH_LSB +: 2])
			vm_inject_pkg::WIDTH_16: width_mask = 64'h0000_0000_0000_ffff;
			vm_inject_pkg::WIDTH_32: width_mask = 64'h0000_0000_ffff_ffff;
			default:                 width_mask = 64'hffff_ffff_ffff_ffff;
		endcase
	end

	always_comb begin
		// any nested level pushes the loaded pointer as is
		ret_ip = guest_ip;
		if ((depth == 2'h0) && sw_like) begin
			ret_ip = guest_ip + {32'h0000_0000, instr_len};
		end
		ret_ip = ret_ip & width_mask;
	end

	always_comb begin
		push.width = mode[vm_inject_pkg::MODE_WIDTH_LSB +: 2];
		push.kind  = vm_inject_pkg::PUSH_FLAGS;
		push.data  = {32'h0000_0000, img_flags};
		if (state == vm_inject_pkg::ST_IP) begin
			push.kind = vm_inject_pkg::PUSH_IP;
			push.data = ret_ip;
		end else if (state == vm_inject_pkg::ST_ERR) begin
			push.kind = vm_inject_pkg::PUSH_ERR;
			push.data = {32'h0000_0000, cur_code};
		end
	end

	assign push_valid = (state == vm_inject_pkg::ST_FLAGS) || (state == vm_inject_pkg::ST_IP)
	                    || (state == vm_inject_pkg::ST_ERR);
	assign fetch_req = '{valid:  state == vm_inject_pkg::ST_FETCH,
	                     vector: cur_vector};

	// ****************************************************************
	// sequencing
	// ****************************************************************
	always_comb begin
		next_state = state;
		case (state)
			vm_inject_pkg::ST_IDLE: begin
				// valid bit alone decides; no execution control can exit here
				if (start && pwdata[vm_inject_pkg::CTRL_START_BIT]
				    && intr_info[vm_inject_pkg::INFO_VALID_BIT]) begin
					next_state = vm_inject_pkg::ST_FETCH;
				end
			end
			vm_inject_pkg::ST_FETCH: begin
				if (fetch_ack) begin
					next_state = vm_inject_pkg::ST_DECIDE;
				end
			end
			vm_inject_pkg::ST_DECIDE: begin
				if ((depth == 2'h0) && redir_candidate && !resp_q.redirect_set) begin
					next_state = vm_inject_pkg::ST_FLAGS;
				end else if (gate_exits) begin
					next_state = vm_inject_pkg::ST_EXIT;
				end else if (any_fault && (depth == vm_inject_pkg::DEPTH_LAST)) begin
					next_state = vm_inject_pkg::ST_FINISH;
				end else if (any_fault) begin
					next_state = nest_exits ? vm_inject_pkg::ST_EXIT : vm_inject_pkg::ST_FETCH;
				end else begin
					next_state = vm_inject_pkg::ST_FLAGS;
				end
			end
			vm_inject_pkg::ST_FLAGS: begin
				if (push_ready) begin
					next_state = vm_inject_pkg::ST_IP;
				end
			end
			vm_inject_pkg::ST_IP: begin
				if (push_ready) begin
					next_state = cur_has_code ? vm_inject_pkg::ST_ERR : vm_inject_pkg::ST_FINISH;
				end
			end
			vm_inject_pkg::ST_ERR: begin
				if (push_ready) begin
					next_state = vm_inject_pkg::ST_FINISH;
				end
			end
			default: begin
				next_state = vm_inject_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state <= vm_inject_pkg::ST_IDLE;
		end else if (ce) begin
			state <= next_state;
		end
	end

	// current event being delivered and its nesting level
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			depth        <= 2'h0;
			cur_vector   <= 8'h00;
			cur_has_code <= 1'b0;
			cur_code     <= vm_inject_pkg::REG_RESET;
			resp_q       <= '0;
			ivt_path     <= 1'b0;
		end else if (ce) begin
			if (start) begin
				depth        <= 2'h0;
				cur_vector   <= intr_info[7:0];
				cur_has_code <= intr_info[vm_inject_pkg::INFO_ERR_BIT];
				cur_code     <= err_code;
				ivt_path     <= 1'b0;
			end else if ((state == vm_inject_pkg::ST_FETCH) && fetch_ack) begin
				resp_q <= fetch_resp;
			end else if (state == vm_inject_pkg::ST_DECIDE) begin
				if ((depth == 2'h0) && redir_candidate && !resp_q.redirect_set) begin
					ivt_path <= 1'b1;
				end else if (any_fault && !gate_exits && !nest_exits
				             && (depth != vm_inject_pkg::DEPTH_LAST)) begin
					depth        <= depth + 2'h1;
					cur_vector   <= nest_vector;
					cur_has_code <= nest_has_code;
					cur_code     <= nest_code;
				end
			end
		end
	end

	// ****************************************************************
	// completion, exits and branch-record side effects
	// ****************************************************************
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			done              <= 1'b0;
			exited            <= 1'b0;
			shutdown          <= 1'b0;
			vm_exit           <= 1'b0;
			branch_record_log <= 1'b0;
			ler_update        <= 1'b0;
			live_flags        <= vm_inject_pkg::REG_RESET;
			vectoring_info    <= vm_inject_pkg::REG_RESET;
		end else if (ce) begin
			vm_exit           <= 1'b0;
			branch_record_log <= 1'b0;
			ler_update        <= 1'b0;
			if (start) begin
				// an entry without the valid bit completes at once with nothing delivered
				done     <= !intr_info[vm_inject_pkg::INFO_VALID_BIT];
				exited   <= 1'b0;
				shutdown <= 1'b0;
			end
			if ((state == vm_inject_pkg::ST_DECIDE) && (next_state == vm_inject_pkg::ST_EXIT)) begin
				vectoring_info <= cur_vectoring;
			end
			if ((state == vm_inject_pkg::ST_DECIDE) && (next_state == vm_inject_pkg::ST_FINISH)) begin
				shutdown <= 1'b1;
			end
			if (state == vm_inject_pkg::ST_EXIT) begin
				vm_exit <= 1'b1;
				exited  <= 1'b1;
				done    <= 1'b1;
			end
			if (state == vm_inject_pkg::ST_FINISH) begin
				done <= 1'b1;
				if (!shutdown) begin
					live_flags <= img_live;
					// logged even for vector 1, which would normally drop the enable first
					branch_record_log <= debug_control_msr[vm_inject_pkg::DBG_LBR_BIT];
					ler_update        <= debug_control_msr[vm_inject_pkg::DBG_LBR_BIT];
				end
			end
		end
	end

endmodule
`default_nettype wire

// file: core/vm_inject_pkg.sv
// constants, field layouts and carriers for the injected-event delivery unit
// assumes one core clock; all users name items as vm_inject_pkg::name
package vm_inject_pkg;

	// ****************************************************************
	// register offsets (apb byte addresses)
	// ****************************************************************
	localparam logic [7:0] OFS_INTR_INFO   = 8'h00;
	localparam logic [7:0] OFS_ERR_CODE    = 8'h04;
	localparam logic [7:0] OFS_INSTR_LEN   = 8'h08;
	localparam logic [7:0] OFS_GUEST_FLAGS = 8'h0c;
	localparam logic [7:0] OFS_GUEST_IP_LO = 8'h10;
	localparam logic [7:0] OFS_GUEST_IP_HI = 8'h14;
	localparam logic [7:0] OFS_EXC_BITMAP  = 8'h18;
	localparam logic [7:0] OFS_MODE        = 8'h1c;
	localparam logic [7:0] OFS_DEBUG_CTL   = 8'h20;
	localparam logic [7:0] OFS_CONTROL     = 8'h24;
	localparam logic [7:0] OFS_STATUS      = 8'h28;
	localparam logic [7:0] OFS_VECTORING   = 8'h2c;
	localparam logic [7:0] OFS_LIVE_FLAGS  = 8'h30;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int INFO_VALID_BIT = 31;
	localparam int INFO_ERR_BIT   = 11;
	localparam int INFO_TYPE_LSB  = 8;
	localparam int EXT_BIT        = 0;
	localparam int FL_TF          = 8;
	localparam int FL_IF          = 9;
	localparam int FL_IO_PRIVILEGE_LEVEL_LSB    = 12;
	localparam int FL_NT          = 14;
	localparam int FL_RF          = 16;
	localparam int FL_VM          = 17;
	localparam int FL_VIF         = 19;
	localparam int MODE_VME_BIT   = 0;
	localparam int MODE_CPL_LSB   = 1;
	localparam int MODE_WIDTH_LSB = 3;
	localparam int DBG_LBR_BIT    = 0;
	localparam int CTRL_START_BIT = 0;

	// ****************************************************************
	// encodings and reset values
	// ****************************************************************
	localparam logic [2:0]  TYPE_EXT_INT  = 3'h0;
	localparam logic [2:0]  TYPE_NMI      = 3'h2;
	localparam logic [2:0]  TYPE_HW_EXC   = 3'h3;
	localparam logic [2:0]  TYPE_SW_INT   = 3'h4;
	localparam logic [2:0]  TYPE_PSW_EXC  = 3'h5;
	localparam logic [2:0]  TYPE_SW_EXC   = 3'h6;
	localparam logic [1:0]  WIDTH_16      = 2'h0;
	localparam logic [1:0]  WIDTH_32      = 2'h1;
	localparam logic [1:0]  WIDTH_64      = 2'h2;
	localparam logic [1:0]  IO_PRIVILEGE_LEVEL_TOP      = 2'h3;
	localparam logic [7:0]  VEC_GP        = 8'h0d;
	localparam logic [7:0]  VEC_DF        = 8'h08;
	localparam logic [31:0] DF_CODE       = 32'h0000_0000;
	localparam logic [2:0]  IDT_CODE_TAIL = 3'h2;
	localparam logic [31:0] REG_RESET     = 32'h0000_0000;
	localparam logic [63:0] IP_RESET      = 64'h0000_0000_0000_0000;
	localparam logic [1:0]  DEPTH_DF      = 2'h2;
	localparam logic [1:0]  DEPTH_LAST    = 2'h3;

	localparam logic [1:0]  PUSH_FLAGS    = 2'h0;
	localparam logic [1:0]  PUSH_IP       = 2'h1;
	localparam logic [1:0]  PUSH_ERR      = 2'h2;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_FETCH  = 3'h1,
		ST_DECIDE = 3'h3,
		ST_FLAGS  = 3'h2,
		ST_IP     = 3'h6,
		ST_ERR    = 3'h7,
		ST_FINISH = 3'h5,
		ST_EXIT   = 3'h4
	} state_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] vector;
	} fetch_req_t;

	typedef struct packed {
		logic        redirect_set;
		logic [1:0]  gate_dpl;
		logic        task_gate;
		logic        trap_gate;
		logic        fault;
		logic [7:0]  fault_vector;
		logic        fault_has_code;
		logic [31:0] fault_code;
	} fetch_resp_t;

	typedef struct packed {
		logic [1:0]  kind;
		logic [1:0]  width;
		logic [63:0] data;
	} push_t;

endpackage

// file: verif/vm_entry_event_injection_tb_top.sv
// bench for the injected-event unit: apb set-up, injections, checks
// assumes ce high; fetch unit and stack sink are played here
`timescale 1ns/1ns
`default_nettype none
module vm_entry_event_injection_tb_top;
	logic core_clk = '0, reset = '1, ce = '1, task_switch_exits = '0, se;
	logic psel = '0, penable = '0, pwrite = '0, fetch_ack = '0, push_ready = '0;
	logic pready, pslverr, push_valid, vm_exit, branch_record_log, ler_update, busy;
	logic [7:0] paddr = 8'h00;
	logic [1:0] descriptor_privilege = 2'h3;
	logic [31:0] pwdata = 32'h0, rd, prdata, live_flags, vectoring_info;
	vm_inject_pkg::fetch_req_t fetch_req;
	vm_inject_pkg::fetch_resp_t fetch_resp;
	vm_inject_pkg::push_t push, got[$];
	int err_total = 0, compares = 0, faults = 0, logs = 0, exits = 0;
	localparam logic [63:0] GIP = 64'h0000_0001_0000_fff0;
	localparam logic [31:0] GFL = 32'h0001_4302;
	vm_entry_event_injection u_vm_entry_event_injection (.core_clk(core_clk), .reset(reset),
		.ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .fetch_req(fetch_req),
		.fetch_ack(fetch_ack), .fetch_resp(fetch_resp), .task_switch_exits(task_switch_exits),
		.push_valid(push_valid), .push_ready(push_ready), .push(push), .vm_exit(vm_exit),
		.branch_record_log(branch_record_log), .ler_update(ler_update), .busy(busy),
		.live_flags(live_flags), .vectoring_info(vectoring_info));
	// a fetch faults while faults is nonzero, so each test sets its nesting depth
	assign fetch_resp = '{1'b0, descriptor_privilege, task_switch_exits, 1'b0, faults != 0, vm_inject_pkg::VEC_GP,
		1'b1, 32'h68};
	always #50 core_clk = ~core_clk;
	// ready toggles each cycle so every pushed word after the first is stalled once
	always @(posedge core_clk) begin
		fetch_ack <= fetch_req.valid && !fetch_ack;
		push_ready <= !push_ready;
		if (fetch_ack && faults != 0) faults <= faults - 1;
		if (push_valid && push_ready) got.push_back(push);
		if (branch_record_log) logs <= logs + 1;
		if (vm_exit) exits <= exits + 1;
	end
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata; se = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("wrong value at %0t: %h vs %h", $time, g, e);
		end
	endtask
	task automatic inject(input logic v, input logic [2:0] ty, input logic ev, input int nf,
		input logic [31:0] bm);
		got.delete();
		faults = nf;
		apb(1'b1, 8'h18, bm);
		apb(1'b1, 8'h00, {v, 19'h0, ev, ty, 8'h21});
		apb(1'b1, 8'h24, 32'h1);
		rd = 32'h0;
		for (int i = 0; i < 50 && rd[2] !== 1'b1; i++) apb(1'b0, 8'h28, 32'h0);
		if (rd[2] !== 1'b1) err_total++;
	endtask
	task automatic conclude();
		if (err_total == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		logic [2:0] tys [6] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
		logic [31:0] ecs [4] = '{32'h68, 32'h69, 32'h69, 32'h0};
		repeat (4) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		apb(1'b1, 8'h04, 32'habc);
		apb(1'b1, 8'h08, 32'h3);
		apb(1'b1, 8'h0c, GFL);
		apb(1'b1, 8'h10, GIP[31:0]);
		apb(1'b1, 8'h14, GIP[63:32]);
		apb(1'b1, 8'h1c, 32'h10);
		apb(1'b1, 8'h20, 32'h1);
		apb(1'b0, 8'h40, 32'h0);
		chk({se, rd}, 33'h1_0000_0000);
		inject(1'b0, 3'h3, 1'b1, 0, 32'h0);
		chk(got.size() + logs, 0);
		foreach (tys[i]) begin
			inject(1'b1, tys[i], tys[i] == 3'h3, 0, 32'h0);
			chk(got.size(), 2 + (tys[i] == 3'h3));
			chk(got[0].data, GFL);
			chk(got[1].data, tys[i][2] ? GIP + 3 : GIP);
			chk(got[1].width, 2'h2);
			chk(got[got.size() - 1].data, tys[i] == 3'h3 ? 64'habc : tys[i][2] ? GIP + 3 : GIP);
			chk(live_flags, 32'h2);
			chk(logs, i + 1);
		end
		for (int j = 0; j < 4; j++) begin
			inject(1'b1, j == 1 ? 3'h3 : 3'h6, 1'b0, j < 2 ? 1 : j, 32'h0);
			chk(got[1].data, GIP);
			chk(got[2].data, ecs[j]);
		end
		apb(1'b0, 8'h20, 32'h0);
		chk(rd, 32'h1);
		descriptor_privilege = 2'h0;
		apb(1'b1, 8'h1c, 32'h12);
		inject(1'b1, 3'h6, 1'b0, 0, 32'h0);
		chk(got[2].data, 64'h214);
		inject(1'b1, 3'h3, 1'b0, 0, 32'h0);
		chk(got.size(), 2);
		apb(1'b1, 8'h0c, GFL | 32'h0002_0000);
		apb(1'b1, 8'h1c, 32'h11);
		inject(1'b1, 3'h4, 1'b0, 0, 32'h0);
		chk({rd[0], got[0].data}, 65'h1_0000_0000_0003_7102);
		chk(live_flags, 32'h0003_4202);
		inject(1'b1, 3'h6, 1'b0, 0, 32'h0);
		chk(rd[0], 1'b0);
		inject(1'b1, 3'h3, 1'b1, 1, 32'h0000_2000);
		chk({exits, got.size()}, {32'd1, 32'd0});
		chk(vectoring_info, 32'h8000_0b21);
		task_switch_exits <= 1'b1;
		inject(1'b1, 3'h0, 1'b0, 0, 32'h0);
		chk({exits, vectoring_info}, {32'd2, 32'h8000_0021});
		conclude();
	end
	initial begin
		#3000000;
		err_total++;
		conclude();
	end
endmodule
bind vm_entry_event_injection vm_inject_props u_vm_inject_props (.core_clk(core_clk),
	.reset(reset), .ce(ce), .push_valid(push_valid), .push_ready(push_ready), .push(push),
	.fetch_req(fetch_req), .vm_exit(vm_exit), .branch_record_log(branch_record_log),
	.ler_update(ler_update), .busy(busy));
`default_nettype wire

// file: verif/vm_inject_props.sv
// assertions on the injected-event unit
// assumes it is bound to the unit; one clock domain
`timescale 1ns/1ns
`default_nettype none
module vm_inject_props (
	input wire logic			core_clk,
	input wire logic			reset,
	input wire logic			ce,
	input wire logic			push_valid,
	input wire logic			push_ready,
	input wire vm_inject_pkg::push_t	push,
	input wire vm_inject_pkg::fetch_req_t	fetch_req,
	input wire logic			vm_exit,
	input wire logic			branch_record_log,
	input wire logic			ler_update,
	input wire logic			busy
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	a_log_pair: assert property (branch_record_log == ler_update)
		else $error("log pulses differ");
	a_log_at_end: assert property (branch_record_log |-> !busy && $past(busy))
		else $error("log pulse off end");
	a_exit_at_end: assert property (vm_exit |-> !busy && $past(busy))
		else $error("exit pulse off end");
	a_exit_once: assert property (vm_exit |=> !vm_exit)
		else $error("exit pulse long");
	a_width_legal: assert property (push_valid |-> push.width != 2'h3)
		else $error("bad push width");
	a_push_holds: assert property (
		push_valid && !(push_ready && ce) |=> push_valid && $stable(push))
		else $error("push word dropped");
	a_fetch_busy: assert property (fetch_req.valid |-> busy)
		else $error("fetch while idle");
	a_ip_after_flags: assert property (
		push_valid && push_ready && ce && push.kind == vm_inject_pkg::PUSH_FLAGS
		|=> push_valid && push.kind == vm_inject_pkg::PUSH_IP)
		else $error("ip not after flags");
endmodule
`default_nettype wire
